// ### logic/hss_pkg.sv
// Package: shared constants and carrier types of the homing search sequencer
package hss_pkg;

  // Widths of the speed and position words
  localparam int SPEED_W = 16;
  localparam int POS_W   = 32;

  // Homing method codes handled here
  localparam logic [7:0] METHOD_12 = 8'h0C;
  localparam logic [7:0] METHOD_13 = 8'h0D;
  localparam logic [7:0] METHOD_14 = 8'h0E;

  // Direction encoding on the motion command
  localparam logic DIR_POS = 1'b1;
  localparam logic DIR_NEG = 1'b0;

  // Reset values
  localparam logic [SPEED_W-1:0] SPEED_RST  = 16'h0000;
  localparam logic [POS_W-1:0]   POS_RST    = 32'h0000_0000;
  localparam logic [7:0]         METHOD_RST = 8'h00;

  // Bit positions of the edge detector lanes
  localparam int LANE_SW  = 0;
  localparam int LANE_OT  = 1;
  localparam int LANE_IDX = 2;
  localparam int LANES    = 3;

  // Sequencer phases
  typedef enum logic [3:0] {
    HSS_IDLE,
    HSS_SEEK_OT,        // Negative at near speed, waiting for overtravel
    HSS_OUT_NEG,        // Outside switch, negative at near speed
    HSS_FALL_POS,       // Positive until switch falling edge
    HSS_FALL_NEG,       // Negative until switch falling edge
    HSS_RISE_POS,       // Positive until switch rising edge
    HSS_IDX_POS,        // Positive at index speed until index pulse
    HSS_IDX_NEG         // Negative at index speed until index pulse
  } hss_phase_t;

  // Motion command toward the control loop
  typedef struct packed {
    logic               en;
    logic               dir;
    logic [SPEED_W-1:0] speed;
  } hss_move_t;

  // Axis sensor inputs
  typedef struct packed {
    logic idx;
    logic ot;
    logic sw;
  } hss_sense_t;

  // Whole sequencer state
  typedef struct packed {
    hss_phase_t       phase;
    logic [7:0]       method;
    hss_move_t        move;
    logic             busy;
    logic             done;
    logic             err;
    logic [POS_W-1:0] home_pos;
  } hss_state_t;

endpackage : hss_pkg

// ### logic/hss_edge.sv
// Edge detector: rising and falling strobes for a group of sensor lanes
`timescale 1ns/10ps
module hss_edge #(
  parameter int W = 3
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rst,   // Synchronous reset, active high
  input  wire logic [W-1:0] level, // Sensor levels
  output logic      [W-1:0] rise,  // High in the same cycle as a 0 to 1 change
  output logic      [W-1:0] fall   // High in the same cycle as a 1 to 0 change
);

  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  // Previous sample; zero at reset so a level high at start reads as a rise
  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

  // Edges compare the live level with the stored one
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule : hss_edge

// ### logic/hss_sequencer.sv
// Homing search sequencer for methods 12, 13 and 14
// Summary of operation
// - Method 12 outside: drive negative at near speed until switch rise (then negative index search) or overtravel.
// - Method 12 after overtravel: positive to switch fall, then negative index search.
// - Method 13 homes on index right of switch falling edge, from negative side.
// - Method 13: negative to switch fall at near speed, then positive index search.
// - Method 13 limit side: overtravel, positive to switch rise, then index search.
// - Method 14 homes on index left of switch falling edge, from negative side.
// - Method 14: negative to switch fall at near speed, then negative index search.
// - Near speed for switch and limit search, index speed for final search.
`timescale 1ns/10ps
module hss_sequencer (
  input  wire logic                        clk,                       // 40 MHz clock
  input  wire logic                        rst,                       // Sync reset, high
  input  wire logic                        start,                     // Begin a homing run
  input  wire logic                        abort,                     // Stop the run now
  input  wire logic [7:0]                  homing_method_select,      // Method code
  input  wire logic [hss_pkg::SPEED_W-1:0] near_sensor_search_speed,  // Switch/limit speed
  input  wire logic [hss_pkg::SPEED_W-1:0] index_search_speed,        // Index search speed
  input  wire logic                        home_switch_input,         // Home switch level
  input  wire logic                        negative_overtravel_input, // Negative limit
  input  wire logic                        index_pulse,               // Encoder index
  input  wire logic [hss_pkg::POS_W-1:0]   position,                  // Actual position
  output hss_pkg::hss_move_t               move,                      // Motion command
  output logic                             busy,                      // Run in progress
  output logic                             done,                      // Home found
  output logic                             err,                       // Run failed
  output logic [hss_pkg::POS_W-1:0]        home_position              // Latched home
);

  hss_pkg::hss_state_t st;
  hss_pkg::hss_state_t next_st;
  hss_pkg::hss_sense_t sense;
  logic [hss_pkg::LANES-1:0] rise;
  logic [hss_pkg::LANES-1:0] fall;

  // Gather sensor levels into one carrier
  assign sense.sw  = home_switch_input;
  assign sense.ot  = negative_overtravel_input;
  assign sense.idx = index_pulse;

  // Strobes follow the live level, so an event acts in the cycle it is sampled
  hss_edge #(
    .W (hss_pkg::LANES)
  ) u_edge (
    .clk   (clk),
    .rst   (rst),
    .level (sense),
    .rise  (rise),
    .fall  (fall)
  );

  // Build a motion command from direction and which speed to use
  function automatic hss_pkg::hss_move_t mk_move(
    input logic                        dir,
    input logic                        use_idx,
    input logic [hss_pkg::SPEED_W-1:0] near_spd,
    input logic [hss_pkg::SPEED_W-1:0] idx_spd
  );
    hss_pkg::hss_move_t m;
    m.en    = 1'b1;
    m.dir   = dir;
    m.speed = use_idx ? idx_spd : near_spd;
    return m;
  endfunction : mk_move

  // Stopped command
  function automatic hss_pkg::hss_move_t stop_move();
    hss_pkg::hss_move_t m;
    m.en    = 1'b0;
    m.dir   = hss_pkg::DIR_NEG;
    m.speed = hss_pkg::SPEED_RST;
    return m;
  endfunction : stop_move

  // Phase sequencing; speeds are re-read each cycle so a live change takes effect
  always_comb begin
    next_st = st;
    case (st.phase)
      hss_pkg::HSS_IDLE: begin
        // Start counts only here, so a repeat while busy is ignored
        if (start) begin
          next_st.method = homing_method_select;
          next_st.done   = 1'b0;
          next_st.err    = 1'b0;
          if (homing_method_select == hss_pkg::METHOD_12) begin
            // Inside the switch, leave it on the positive side first
            next_st.phase = home_switch_input ? hss_pkg::HSS_FALL_POS
                                              : hss_pkg::HSS_OUT_NEG;
            next_st.busy  = 1'b1;
          end else if (homing_method_select == hss_pkg::METHOD_13 ||
                       homing_method_select == hss_pkg::METHOD_14) begin
            next_st.phase = hss_pkg::HSS_FALL_NEG;
            next_st.busy  = 1'b1;
          end else begin
            // Other methods belong to other blocks
            next_st.err = 1'b1;
          end
        end
      end
      hss_pkg::HSS_OUT_NEG: begin
        // Method 12 outside: switch rise heading negative, else limit first
        if (sense.ot) begin
          next_st.phase = hss_pkg::HSS_FALL_POS;
        end else if (rise[hss_pkg::LANE_SW]) begin
          next_st.phase = hss_pkg::HSS_IDX_NEG;
        end
      end
      hss_pkg::HSS_SEEK_OT: begin
        // Spare limit search; no start path enters it at present
        if (sense.ot) begin
          next_st.phase = hss_pkg::HSS_RISE_POS;
        end
      end
      hss_pkg::HSS_FALL_NEG: begin
        // Inside or outside alike, a fall heading negative is the left switch edge
        if (sense.ot) begin
          // Limit reached before the switch: reverse
          next_st.phase = hss_pkg::HSS_RISE_POS;
        end else if (fall[hss_pkg::LANE_SW]) begin
          if (st.method == hss_pkg::METHOD_13) begin
            next_st.phase = hss_pkg::HSS_IDX_POS;
          end else begin
            next_st.phase = hss_pkg::HSS_IDX_NEG;
          end
        end
      end
      hss_pkg::HSS_FALL_POS: begin
        // Method 12: right edge of switch, then back left for the index
        if (fall[hss_pkg::LANE_SW]) begin
          next_st.phase = hss_pkg::HSS_IDX_NEG;
        end
      end
      hss_pkg::HSS_RISE_POS: begin
        // Limit path: a rise heading positive is the left switch edge
        if (rise[hss_pkg::LANE_SW]) begin
          next_st.phase = (st.method == hss_pkg::METHOD_13) ? hss_pkg::HSS_IDX_POS
                                                             : hss_pkg::HSS_IDX_NEG;
        end
      end
      hss_pkg::HSS_IDX_POS,
      hss_pkg::HSS_IDX_NEG: begin
        // Limit during the negative index search means no index was reachable
        if (st.phase == hss_pkg::HSS_IDX_NEG && sense.ot) begin
          next_st.phase = hss_pkg::HSS_IDLE;
          next_st.busy  = 1'b0;
          next_st.err   = 1'b1;
        end else if (rise[hss_pkg::LANE_IDX]) begin
          next_st.phase    = hss_pkg::HSS_IDLE;
          next_st.busy     = 1'b0;
          next_st.done     = 1'b1;
          next_st.home_pos = position;
        end
      end
      default: begin
        next_st.phase = hss_pkg::HSS_IDLE;
        next_st.busy  = 1'b0;
      end
    endcase

    // Abort wins over any step; motion stops on the next edge
    // Abort in idle is ignored so a stray pulse leaves the flags alone
    if (abort && st.phase != hss_pkg::HSS_IDLE) begin
      next_st.phase = hss_pkg::HSS_IDLE;
      next_st.busy  = 1'b0;
      next_st.err   = 1'b1;
    end

    // Motion command follows the phase being entered
    // Registered, so the drive never sees a decode glitch
    case (next_st.phase)
      hss_pkg::HSS_SEEK_OT,
      hss_pkg::HSS_OUT_NEG,
      hss_pkg::HSS_FALL_NEG: begin
        next_st.move = mk_move(hss_pkg::DIR_NEG, 1'b0, near_sensor_search_speed,
                               index_search_speed);
      end
      hss_pkg::HSS_FALL_POS,
      hss_pkg::HSS_RISE_POS: begin
        next_st.move = mk_move(hss_pkg::DIR_POS, 1'b0, near_sensor_search_speed,
                               index_search_speed);
      end
      hss_pkg::HSS_IDX_POS: begin
        next_st.move = mk_move(hss_pkg::DIR_POS, 1'b1, near_sensor_search_speed,
                               index_search_speed);
      end
      hss_pkg::HSS_IDX_NEG: begin
        next_st.move = mk_move(hss_pkg::DIR_NEG, 1'b1, near_sensor_search_speed,
                               index_search_speed);
      end
      default: begin
        next_st.move = stop_move();
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st.phase    <= hss_pkg::HSS_IDLE;
      st.method   <= hss_pkg::METHOD_RST;
      st.move     <= '0;
      st.busy     <= 1'b0;
      st.done     <= 1'b0;
      st.err      <= 1'b0;
      st.home_pos <= hss_pkg::POS_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops
  assign move          = st.move;
  assign busy          = st.busy;
  assign done          = st.done;
  assign err           = st.err;
  assign home_position = st.home_pos;

endmodule : hss_sequencer

// ### bench/hss_sequencer_properties.sv
// Checker of the homing search sequencer port behaviour
`timescale 1ns/10ps
module hss_seq_props (
  input wire logic                        clk,                       // Clock
  input wire logic                        rst,                       // Sync reset
  input wire logic                        start,                     // Run request
  input wire logic                        abort,                     // Stop request
  input wire logic [7:0]                  homing_method_select,      // Method code
  input wire logic [hss_pkg::SPEED_W-1:0] near_sensor_search_speed,  // Near speed
  input wire logic [hss_pkg::SPEED_W-1:0] index_search_speed,        // Index speed
  input wire logic                        home_switch_input,         // Switch
  input wire logic                        negative_overtravel_input, // Limit
  input wire logic                        index_pulse,               // Index
  input wire logic [hss_pkg::POS_W-1:0]   position,                  // Position
  input hss_pkg::hss_move_t               move,                      // Motion command
  input wire logic                        busy,                      // Run flag
  input wire logic                        done,                      // Home found
  input wire logic [hss_pkg::POS_W-1:0]   home_position              // Latched home
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] meth;
  // Method of the run in progress, since the bus value may change mid-run
  always_ff @(posedge clk) begin
    if (rst) meth <= 8'h00;
    else if (start && !busy) meth <= homing_method_select;
  end
  sequence s_take;
    start && !busy && !abort;
  endsequence
  sequence s_near(logic d);
    move.en && move.dir == d && move.speed == $past(near_sensor_search_speed);
  endsequence
  sequence s_idx(logic d);
    move.en && move.dir == d && move.speed == $past(index_search_speed);
  endsequence
  AST_START_NEG: assert property (s_take ##0 (homing_method_select == hss_pkg::METHOD_13 ||
    homing_method_select == hss_pkg::METHOD_14) |=> busy ##0 s_near(hss_pkg::DIR_NEG))
    else $error("method 13 or 14 start not negative at near speed");
  AST_M12_START: assert property (s_take ##0 homing_method_select == hss_pkg::METHOD_12
    |=> s_near($past(home_switch_input))) else $error("method 12 start direction wrong");
  AST_OT_TURN: assert property (s_near(hss_pkg::DIR_NEG) ##0 negative_overtravel_input
    |-> ##[1:3] s_near(hss_pkg::DIR_POS)) else $error("no positive turn at overtravel");
  AST_FALL13: assert property (meth == hss_pkg::METHOD_13 && $fell(home_switch_input) ##0
    s_near(hss_pkg::DIR_NEG) |-> ##[1:3] s_idx(hss_pkg::DIR_POS))
    else $error("method 13 fall not followed by positive index search");
  AST_FALL14: assert property (meth == hss_pkg::METHOD_14 && $fell(home_switch_input) ##0
    s_near(hss_pkg::DIR_NEG) |-> ##[1:3] s_idx(hss_pkg::DIR_NEG))
    else $error("method 14 fall not followed by negative index search");
  AST_RISE13: assert property (meth == hss_pkg::METHOD_13 && $rose(home_switch_input) ##0
    s_near(hss_pkg::DIR_POS) |-> ##[1:3] s_idx(hss_pkg::DIR_POS))
    else $error("method 13 rise not followed by index search");
  AST_FALL12: assert property (meth == hss_pkg::METHOD_12 && $fell(home_switch_input) ##0
    s_near(hss_pkg::DIR_POS) |-> ##[1:3] s_idx(hss_pkg::DIR_NEG))
    else $error("method 12 fall not followed by negative index search");
  AST_IDX_DONE: assert property ($rose(index_pulse) && !abort ##0 s_idx(move.dir)
    |-> ##[1:3] done) else $error("index in final search did not finish run");
  AST_DONE_STOP: assert property ($rose(done) |-> !busy && !move.en &&
    home_position == $past(position)) else $error("home latch or stop wrong");
endmodule : hss_seq_props

bind hss_sequencer hss_seq_props u_props (.clk, .rst, .start, .abort, .homing_method_select,
  .near_sensor_search_speed, .index_search_speed, .home_switch_input, .negative_overtravel_input,
  .index_pulse, .position, .move, .busy, .done, .home_position);

// ### bench/hss_axis_model.sv
// Axis model: integrates motion, yields switch, limit and index levels
`timescale 1ns/10ps
module hss_axis_model #(
  parameter int STEP = 4 // Cycles per count, so each index stays high a few cycles
) (
  input wire logic         clk,      // Bench clock
  input wire logic         load,     // Place the axis
  input wire logic [31:0]  load_pos, // Placement
  input hss_pkg::hss_move_t move,    // Motion command
  output logic             sw,       // Switch on for 40..60
  output logic             ot,       // Limit at 10 and below
  output logic             idx,      // Index every 16 counts
  output logic [31:0]      pos       // Actual position
);
  int cnt = 0;
  // Moves on the falling edge, away from the design's sampling edge
  always @(negedge clk) begin
    if (load) begin
      pos <= load_pos;
      cnt <= 0;
    end else if (move.en === 1'b1) begin
      cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
      if (cnt == STEP - 1) pos <= (move.dir === hss_pkg::DIR_POS) ? pos + 1 : pos - 1;
    end
  end
  assign sw  = (pos >= 32'h0000_0028) && (pos <= 32'h0000_003C);
  assign ot  = (pos <= 32'h0000_000A);
  assign idx = (pos[3:0] == 4'h0) && (pos != 32'h0000_0000);
endmodule : hss_axis_model

// ### bench/tb_top.sv
// Testbench of the homing search sequencer
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, abort = 1'b0, load = 1'b1;
  logic [7:0]  sel = 8'h00;
  logic [31:0] load_pos = 32'h0000_0064;
  logic        sw, ot, idx, busy, done, err;
  logic [31:0] pos, home;
  hss_pkg::hss_move_t move;
  int n_fail = 0, num_checks = 0, cyc = 0;
  hss_sequencer uut (.clk(clk), .rst(rst), .start(start), .abort(abort),
    .homing_method_select(sel), .near_sensor_search_speed(16'h0123),
    .index_search_speed(16'h0045), .home_switch_input(sw), .negative_overtravel_input(ot),
    .index_pulse(idx), .position(pos), .move(move), .busy(busy), .done(done), .err(err),
    .home_position(home));
  hss_axis_model axis (.clk(clk), .load(load), .load_pos(load_pos), .move(move), .sw(sw),
    .ot(ot), .idx(idx), .pos(pos));
  initial forever #12.5 clk = ~clk;
  // Cycle ceiling well above nine homing runs of a few hundred cycles each and the abort test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  // Non-blocking placement, as the axis model samples load on this same edge
  task go(input logic [7:0] m, input logic [31:0] p0);
    @(negedge clk); load <= 1'b1; load_pos <= p0; sel = m;
    @(negedge clk); load <= 1'b0;
    repeat (3) @(negedge clk);
    start = 1'b1;
    @(negedge clk); start = 1'b0;
  endtask : go
  task run(input logic [7:0] m, input logic [31:0] p0, input logic [31:0] e, input logic d);
    int n;
    logic [15:0] last;
    go(m, p0);
    chk("busy", 1, busy);
    chk("speed", 32'h0123, move.speed);
    chk("dir", d, move.dir);
    last = 16'h0000;
    // Last speed seen while moving must be the index speed
    for (n = 0; n < 3000 && done !== 1'b1 && err !== 1'b1; n++) begin
      if (move.en === 1'b1) last = move.speed;
      @(negedge clk);
    end
    chk("idx_speed", 32'h0045, last);
    chk("err", 0, err);
    chk("done", 1, done);
    chk("home", e, home);
    chk("en", 0, move.en);
  endtask : run
  task t_m13_out;
    run(hss_pkg::METHOD_13, 32'h0000_0064, 32'h0000_0030, hss_pkg::DIR_NEG);
  endtask : t_m13_out
  task t_m13_in;
    run(hss_pkg::METHOD_13, 32'h0000_0032, 32'h0000_0030, hss_pkg::DIR_NEG);
  endtask : t_m13_in
  task t_m13_lim;
    run(hss_pkg::METHOD_13, 32'h0000_001E, 32'h0000_0030, hss_pkg::DIR_NEG);
  endtask : t_m13_lim
  task t_m14_out;
    run(hss_pkg::METHOD_14, 32'h0000_0064, 32'h0000_0020, hss_pkg::DIR_NEG);
  endtask : t_m14_out
  task t_m14_in;
    run(hss_pkg::METHOD_14, 32'h0000_0032, 32'h0000_0020, hss_pkg::DIR_NEG);
  endtask : t_m14_in
  task t_m14_lim;
    run(hss_pkg::METHOD_14, 32'h0000_001E, 32'h0000_0020, hss_pkg::DIR_NEG);
  endtask : t_m14_lim
  task t_m12_out;
    run(hss_pkg::METHOD_12, 32'h0000_0064, 32'h0000_0030, hss_pkg::DIR_NEG);
  endtask : t_m12_out
  task t_m12_in;
    run(hss_pkg::METHOD_12, 32'h0000_0032, 32'h0000_0030, hss_pkg::DIR_POS);
  endtask : t_m12_in
  task t_m12_lim;
    run(hss_pkg::METHOD_12, 32'h0000_001E, 32'h0000_0030, hss_pkg::DIR_NEG);
  endtask : t_m12_lim
  task t_abort;
    go(hss_pkg::METHOD_13, 32'h0000_0064);
    repeat (20) @(negedge clk);
    abort = 1'b1;
    @(negedge clk); abort = 1'b0;
    chk("abort_err", 1, err);
    chk("abort_en", 0, move.en);
    chk("abort_busy", 0, busy);
    go(8'h0B, 32'h0000_0064); // Unsupported method must not move
    chk("bad_en", 0, move.en);
    chk("bad_busy", 0, busy);
  endtask : t_abort
  task stop_test;
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Reset for three cycles, then each scenario in turn
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_m13_out();
    t_m13_in();
    t_m13_lim();
    t_m14_out();
    t_m14_in();
    t_m14_lim();
    t_m12_out();
    t_m12_in();
    t_m12_lim();
    t_abort();
    stop_test();
  end
endmodule : tb_top
